// ===== include/tce_pkg.sv
`default_nettype none
package tce_pkg;
   localparam logic [3:0] OPC_NEXT = 4'h0;
   localparam logic [3:0] OPC_LDPTR = 4'h1;
   localparam logic [3:0] OPC_LDACC = 4'h2;
   localparam logic [3:0] OPC_STEP = 4'h3;
   localparam logic [3:0] OPC_PUSH = 4'h4;
   localparam logic [3:0] OPC_PULL = 4'h5;
   localparam logic [3:0] OPC_CALL = 4'h6;
   localparam logic [3:0] OPC_RET = 4'h7;
   localparam logic [3:0] OPC_PULLACC = 4'h8;
   localparam logic [3:0] OPC_LDSTEP = 4'h9;
   localparam logic [2:0] CYC_NEXT = 3'h4;
   localparam logic [2:0] CYC_LDPTR = 3'h5;
   localparam logic [2:0] CYC_LDACC = 3'h3;
   localparam logic [2:0] CYC_STEP = 3'h3;
   localparam logic [2:0] CYC_PUSH = 3'h4;
   localparam logic [2:0] CYC_PULL = 3'h6;
   localparam logic [2:0] CYC_CALL = 3'h5;
   localparam logic [2:0] CYC_RET = 3'h2;
   localparam logic [2:0] CYC_PULLACC = 3'h6;
   localparam logic [2:0] CYC_LDSTEP = 3'h3;
   localparam logic [2:0] CYC_ILLEGAL = 3'h0;
   localparam logic [7:0] STACK_PAGE = 8'h01;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'hff;
   localparam logic [7:0] ACC_RESET = 8'h00;

   typedef enum logic [1:0] {PCMD_HOLD, PCMD_LOAD, PCMD_INC1, PCMD_INC2}
      tce_pcmd_t;

   function automatic logic [15:0] tce_add16(input logic [15:0] a,
                                             input logic [15:0] b);
      return a + b;
   endfunction : tce_add16

   function automatic logic [7:0] tce_add8(input logic [7:0] a,
                                           input logic [7:0] b);
      return a + b;
   endfunction : tce_add8

   function automatic logic [2:0] tce_cycles(input logic [3:0] op);
      case (op)
         OPC_NEXT: return CYC_NEXT;
         OPC_LDPTR: return CYC_LDPTR;
         OPC_LDACC: return CYC_LDACC;
         OPC_STEP: return CYC_STEP;
         OPC_PUSH: return CYC_PUSH;
         OPC_PULL: return CYC_PULL;
         OPC_CALL: return CYC_CALL;
         OPC_RET: return CYC_RET;
         OPC_PULLACC: return CYC_PULLACC;
         OPC_LDSTEP: return CYC_LDSTEP;
         default: return CYC_ILLEGAL;
      endcase
   endfunction : tce_cycles
endpackage : tce_pkg
`default_nettype wire

// ===== include/tce_ptr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tce_ptr_if;
   import tce_pkg::*;
   tce_pcmd_t cmd;
   logic [15:0] val;
   logic [15:0] ptr;
   modport seq (output cmd, output val, input ptr);
   modport store (input cmd, input val, output ptr);
endinterface : tce_ptr_if
`default_nettype wire

// ===== rtl/tce_ptr_store.sv
`timescale 1ns/10ps
`default_nettype none
module tce_ptr_store
   import tce_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   tce_ptr_if.store pif
);
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic [15:0] inc_by;

   // The pointer is plain 16-bit arithmetic, so stepping past the top wraps.
   assign inc_by = (pif.cmd == PCMD_INC2) ? 16'h0002 : 16'h0001; // RL16
   assign ptr_d = (pif.cmd == PCMD_LOAD) ? pif.val :
                  (pif.cmd == PCMD_HOLD) ? ptr_q :
                  tce_add16(ptr_q, inc_by); // RL16
   assign pif.ptr = ptr_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_q <= PTR_RESET;
      end else if (ce) begin
         ptr_q <= ptr_d;
      end
   end
endmodule : tce_ptr_store
`default_nettype wire

// ===== rtl/tce_exec.sv
// Notes on behaviour
// RL1 - Next-word reads two bytes at the pointer into the program counter.
// RL2 - Next-word then advances the pointer by two.
// RL3 - Pointer-indirect load replaces the pointer with the word it addresses.
// RL4 - Accumulator load reads the byte at the pointer; pointer unchanged.
// RL5 - Pointer step adds one to the pointer and changes nothing else.
// RL6 - Push writes pointer high byte first, stack pointer drops by two.
// RL7 - Pull loads pointer low byte first, stack pointer rises by two.
// RL8 - Call first sets the pointer to instruction address plus one.
// RL9 - Call jumps to the address stored at its two-byte operand.
// RL10 - Call then adds two so the pointer holds the return address.
// RL11 - Pointer-to-counter copies the pointer into the program counter.
// RL12 - Pull-and-load pulls pointer, raises stack by two, loads byte, steps.
// RL13 - Load-and-step loads the byte at the pointer, then steps pointer.
// RL14 - Cycles: next 4, indirect load 5, acc load 3, step 3.
// RL15 - Cycles: push 4, pull 6, call 5, to-counter 2, pull-load 6, load 3.
// RL16 - Pointer is 16 bits, wraps, and words are fetched low byte first.
// RL17 - No status flags change; the core handles flags on accumulator loads.
`timescale 1ns/10ps
`default_nettype none
module tce_exec
   import tce_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic START,
   input wire logic [3:0] OP_IN,
   input wire logic [15:0] PC_IN,
   input wire logic [7:0] SP_IN,
   input wire logic PTR_WR,
   input wire logic [15:0] PTR_WDATA,
   input wire logic [7:0] MEM_RDATA,
   output logic [15:0] MEM_ADDR,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [7:0] MEM_WDATA,
   output logic [15:0] PC_OUT,
   output logic PC_LOAD,
   output logic [7:0] SP_OUT,
   output logic SP_LOAD,
   output logic [7:0] ACC_OUT,
   output logic ACC_LOAD,
   output logic [15:0] PTR_OUT,
   output logic BUSY,
   output logic DONE
);
   tce_ptr_if pif ();

   tce_ptr_store u_ptr (
      .clk (CLK),
      .arst_n (ARST_N),
      .ce (CE),
      .pif (pif.store)
   );

   logic busy_q, done_q, mem_rd_q, mem_wr_q;
   logic pc_ld_q, sp_ld_q, acc_ld_q;
   logic [2:0] step_q;
   logic [3:0] op_q;
   logic [7:0] lo_q, sp_q, acc_q, mem_wdata_q;
   logic [15:0] pc_q, mem_addr_q;

   // A start with an unknown code is not taken; the core sees BUSY stay low.
   wire legal = tce_cycles(OP_IN) != CYC_ILLEGAL;
   wire take = START & ~busy_q & legal;
   wire act = take | busy_q;
   wire [3:0] op = busy_q ? op_q : OP_IN;
   wire [2:0] st = busy_q ? step_q : 3'h0;
   wire [7:0] sp_cur = busy_q ? sp_q : SP_IN;
   wire [15:0] ptr = pif.ptr;
   wire [15:0] word = {MEM_RDATA, lo_q}; // RL16
   wire last = busy_q & (step_q == tce_cycles(op_q) - 3'h1); // RL14 RL15

   wire o_next = op == OPC_NEXT;
   wire o_ldptr = op == OPC_LDPTR;
   wire o_ldacc = op == OPC_LDACC;
   wire o_step = op == OPC_STEP;
   wire o_push = op == OPC_PUSH;
   wire o_pull = op == OPC_PULL;
   wire o_call = op == OPC_CALL;
   wire o_ret = op == OPC_RET;
   wire o_pullacc = op == OPC_PULLACC;
   wire o_ldstep = op == OPC_LDSTEP;

   wire e0 = act & (st == 3'h0);
   wire e1 = act & (st == 3'h1);
   wire e2 = act & (st == 3'h2);
   wire e3 = act & (st == 3'h3);

   // Memory answers one cycle after a read strobe, so each byte is caught
   // two edges after its request was registered.
   wire rd_ptr = e0 & (o_next | o_ldptr | o_ldacc | o_ldstep) // RL4 RL13
               | e1 & o_call; // RL9
   wire rd_ptr1 = e1 & (o_next | o_ldptr) | e2 & o_call; // RL1 RL3
   wire rd_sp1 = e0 & (o_pull | o_pullacc); // RL7 RL12
   wire rd_sp2 = e1 & (o_pull | o_pullacc);
   // The fresh pointer word is used as the address at once; waiting for the
   // pointer register would cost a cycle the instruction does not have.
   wire rd_new = e3 & o_pullacc; // RL12
   wire wr_hi = e0 & o_push; // RL6
   wire wr_lo = e1 & o_push; // RL6
   wire cap_lo = e2 & (o_next | o_ldptr | o_pull | o_pullacc)
               | e3 & o_call;

   wire [15:0] addr_d = rd_ptr ? ptr :
                        rd_ptr1 ? tce_add16(ptr, 16'h0001) :
                        rd_sp1 ? {STACK_PAGE, tce_add8(sp_cur, 8'h01)} :
                        rd_sp2 ? {STACK_PAGE, tce_add8(sp_cur, 8'h02)} :
                        rd_new ? word :
                        wr_hi ? {STACK_PAGE, sp_cur} :
                        wr_lo ? {STACK_PAGE, tce_add8(sp_cur, 8'hff)} :
                        mem_addr_q;
   wire rd_d = rd_ptr | rd_ptr1 | rd_sp1 | rd_sp2 | rd_new;
   wire wr_d = wr_hi | wr_lo;
   wire [7:0] wdata_d = wr_hi ? ptr[15:8] :
                        wr_lo ? ptr[7:0] : mem_wdata_q;

   wire pc_ld_d = last & (o_next | o_call | o_ret); // RL1 RL9 RL11
   wire [15:0] pc_d = !pc_ld_d ? pc_q : o_ret ? ptr : word; // RL11
   wire sp_ld_d = last & (o_push | o_pull | o_pullacc);
   wire [7:0] sp_d = take ? SP_IN :
                     !sp_ld_d ? sp_q :
                     o_push ? tce_add8(sp_q, 8'hfe) : // RL6
                     tce_add8(sp_q, 8'h02); // RL7 RL12
   // Only the value moves here; the core applies its own flag convention.
   wire acc_ld_d = last & (o_ldacc | o_pullacc | o_ldstep); // RL17
   wire [7:0] acc_d = acc_ld_d ? MEM_RDATA : acc_q; // RL4 RL12 RL13

   wire p_ext = ~act & PTR_WR;
   wire p_call = e0 & o_call; // RL8
   wire p_word = e3 & (o_ldptr | o_pull | o_pullacc); // RL3 RL7 RL12
   wire p_inc2 = last & (o_next | o_call); // RL2 RL10
   wire p_inc1 = last & (o_step | o_pullacc | o_ldstep); // RL5 RL12 RL13

   assign pif.cmd = (p_ext | p_call | p_word) ? PCMD_LOAD :
                    p_inc2 ? PCMD_INC2 :
                    p_inc1 ? PCMD_INC1 : PCMD_HOLD;
   assign pif.val = p_ext ? PTR_WDATA :
                    p_call ? tce_add16(PC_IN, 16'h0001) : word; // RL8

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         step_q <= 3'h0;
         op_q <= OPC_NEXT;
      end else if (CE) begin
         busy_q <= take | (busy_q & ~last);
         done_q <= last;
         step_q <= take ? 3'h1 : busy_q ? step_q + 3'h1 : 3'h0;
         op_q <= take ? OP_IN : op_q;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         mem_wdata_q <= 8'h00;
         lo_q <= 8'h00;
      end else if (CE) begin
         mem_rd_q <= rd_d;
         mem_wr_q <= wr_d;
         mem_addr_q <= addr_d;
         mem_wdata_q <= wdata_d;
         lo_q <= cap_lo ? MEM_RDATA : lo_q; // RL16
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pc_q <= PC_RESET;
         pc_ld_q <= 1'b0;
         sp_q <= SP_RESET;
         sp_ld_q <= 1'b0;
         acc_q <= ACC_RESET;
         acc_ld_q <= 1'b0;
      end else if (CE) begin
         pc_q <= pc_d;
         pc_ld_q <= pc_ld_d;
         sp_q <= sp_d;
         sp_ld_q <= sp_ld_d;
         acc_q <= acc_d;
         acc_ld_q <= acc_ld_d;
      end
   end

   assign MEM_ADDR = mem_addr_q;
   assign MEM_RD = mem_rd_q;
   assign MEM_WR = mem_wr_q;
   assign MEM_WDATA = mem_wdata_q;
   assign PC_OUT = pc_q;
   assign PC_LOAD = pc_ld_q;
   assign SP_OUT = sp_q;
   assign SP_LOAD = sp_ld_q;
   assign ACC_OUT = acc_q;
   assign ACC_LOAD = acc_ld_q;
   assign PTR_OUT = pif.ptr;
   assign BUSY = busy_q;
   assign DONE = done_q;

   // A frozen clock enable would stretch every count below, so checks are disabled while it is low.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N || !CE);

   sequence s_take(logic [3:0] code);
      take && OP_IN == code;
   endsequence

   sequence s_push_hi;
      MEM_WR && MEM_WDATA == PTR_OUT[15:8] && MEM_ADDR[15:8] == STACK_PAGE;
   endsequence

   sequence s_push_lo;
      MEM_WR && MEM_WDATA == PTR_OUT[7:0];
   endsequence

   sequence s_pull_reads;
      MEM_RD && MEM_ADDR == {STACK_PAGE, 8'(SP_OUT + 8'h01)} ##1
      MEM_RD && MEM_ADDR == {STACK_PAGE, 8'(SP_OUT + 8'h02)};
   endsequence

   next_pc_load_a: assert property ( // RL1
      s_take(OPC_NEXT) |-> ##4 (DONE && PC_LOAD &&
         PC_OUT == {$past(MEM_RDATA), $past(MEM_RDATA, 2)}))
      else $error("next-word did not load the counter");

   next_ptr_two_a: assert property ( // RL2
      s_take(OPC_NEXT) |-> ##4 (PTR_OUT == 16'($past(PTR_OUT, 4) + 16'h2)))
      else $error("next-word did not advance the pointer by two");

   ind_ptr_load_a: assert property ( // RL3
      s_take(OPC_LDPTR) |-> ##4 !DONE ##1 (DONE && !PC_LOAD &&
         PTR_OUT == {$past(MEM_RDATA, 2), $past(MEM_RDATA, 3)}))
      else $error("indirect pointer load wrong");

   acc_via_ptr_a: assert property ( // RL4
      s_take(OPC_LDACC) |-> ##1 (MEM_RD && MEM_ADDR == PTR_OUT) ##2
         (DONE && ACC_LOAD && ACC_OUT == $past(MEM_RDATA) &&
         PTR_OUT == $past(PTR_OUT, 3)))
      else $error("accumulator load via pointer wrong");

   ptr_step_a: assert property ( // RL5
      s_take(OPC_STEP) |-> ##3 (DONE && !PC_LOAD && !SP_LOAD &&
         !ACC_LOAD && PTR_OUT == 16'($past(PTR_OUT, 3) + 16'h1)))
      else $error("pointer step wrong");

   ptr_push_a: assert property ( // RL6
      s_take(OPC_PUSH) |-> ##1 s_push_hi ##1 s_push_lo ##2
         (DONE && SP_LOAD && SP_OUT == 8'($past(SP_OUT, 3) - 8'h2)))
      else $error("pointer push wrong");

   ptr_pull_a: assert property ( // RL7
      s_take(OPC_PULL) |-> ##1 s_pull_reads ##4 (DONE && SP_LOAD &&
         SP_OUT == 8'($past(SP_OUT, 5) + 8'h2) &&
         PTR_OUT == {$past(MEM_RDATA, 3), $past(MEM_RDATA, 4)}))
      else $error("pointer pull wrong");

   call_via_ptr_a: assert property ( // RL8 RL9 RL10
      s_take(OPC_CALL) |-> ##1 (PTR_OUT == 16'($past(PC_IN) + 16'h1)) ##4
         (DONE && PC_LOAD &&
         PC_OUT == {$past(MEM_RDATA), $past(MEM_RDATA, 2)} &&
         PTR_OUT == 16'($past(PTR_OUT, 4) + 16'h2)))
      else $error("call via pointer wrong");

   ptr_return_a: assert property ( // RL11
      s_take(OPC_RET) |-> ##2 (DONE && PC_LOAD &&
         PC_OUT == $past(PTR_OUT, 2)))
      else $error("pointer to counter wrong");

   pull_load_acc_a: assert property ( // RL12
      s_take(OPC_PULLACC) |-> ##1 s_pull_reads ##4 (DONE && SP_LOAD &&
         ACC_LOAD && ACC_OUT == $past(MEM_RDATA) &&
         PTR_OUT == 16'($past(PTR_OUT, 2) + 16'h1)))
      else $error("pull and load wrong");

   load_step_a: assert property ( // RL13
      s_take(OPC_LDSTEP) |-> ##3 (DONE && ACC_LOAD &&
         ACC_OUT == $past(MEM_RDATA) &&
         PTR_OUT == 16'($past(PTR_OUT, 3) + 16'h1)))
      else $error("load and step wrong");

   busy_len_a: assert property ( // RL14 RL15
      take |=> BUSY [*2] or (BUSY ##1 DONE))
      else $error("instruction ended too early");

   bad_code_idle_a: assert property ( // RL14
      START && !BUSY && !legal |=> (!BUSY && !DONE && !MEM_RD && !MEM_WR))
      else $error("unknown code started an instruction");

   pull_acc_sp_a: assert property ( // RL12
      s_take(OPC_PULLACC) |-> ##4 (MEM_RD && MEM_ADDR == PTR_OUT) ##2
         (SP_OUT == 8'($past(SP_OUT, 5) + 8'h2)))
      else $error("pull and load stack or address wrong");

   ptr_ext_load_a: assert property ( // RL16
      PTR_WR && !act |=> (PTR_OUT == $past(PTR_WDATA)))
      else $error("external pointer load wrong");

   ret_no_mem_a: assert property ( // RL11
      s_take(OPC_RET) |=> (!MEM_RD && !MEM_WR && !SP_LOAD) ##1
         (PTR_OUT == $past(PTR_OUT, 2)))
      else $error("pointer to counter touched memory or pointer");
endmodule : tce_exec
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
   import tce_pkg::*;
;
   logic CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic CE = 1'b1;
   logic START = 1'b0;
   logic [3:0] OP_IN = 4'h0;
   logic [15:0] PC_IN = 16'h0000;
   logic [7:0] SP_IN = 8'h00;
   logic PTR_WR = 1'b0;
   logic [15:0] PTR_WDATA = 16'h0000;
   logic [7:0] MEM_RDATA = 8'h00;
   logic [15:0] MEM_ADDR, PC_OUT, PTR_OUT;
   logic [7:0] MEM_WDATA, SP_OUT, ACC_OUT;
   logic MEM_RD, MEM_WR, PC_LOAD, SP_LOAD, ACC_LOAD, BUSY, DONE;
   logic [7:0] mem [0:65535];
   logic [15:0] rlog [$];
   logic [15:0] wlog [$];
   int err_total = 0;
   int checked = 0;

   tce_exec u_dut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .START(START),
      .OP_IN(OP_IN), .PC_IN(PC_IN), .SP_IN(SP_IN), .PTR_WR(PTR_WR),
      .PTR_WDATA(PTR_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR),
      .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
      .PC_OUT(PC_OUT), .PC_LOAD(PC_LOAD), .SP_OUT(SP_OUT),
      .SP_LOAD(SP_LOAD), .ACC_OUT(ACC_OUT), .ACC_LOAD(ACC_LOAD),
      .PTR_OUT(PTR_OUT), .BUSY(BUSY), .DONE(DONE));

   always #50 CLK = ~CLK;

   // Memory answers one cycle after the strobe; idle data toggles so a
   // stale byte can never be mistaken for a fresh one.
   always @(posedge CLK) begin
      if (CE && ARST_N) begin
         if (MEM_RD) begin
            MEM_RDATA <= mem[MEM_ADDR];
            rlog.push_back(MEM_ADDR);
         end else begin
            MEM_RDATA <= ~MEM_RDATA;
         end
         if (MEM_WR) begin
            mem[MEM_ADDR] <= MEM_WDATA;
            wlog.push_back(MEM_ADDR);
         end
      end
   end

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic set_ptr(input logic [15:0] v);
      PTR_WR = 1'b1;
      PTR_WDATA = v;
      @(posedge CLK);
      #1 PTR_WR = 1'b0;
      @(posedge CLK);
      #1 `CHK(PTR_OUT, v)
   endtask : set_ptr

   // Runs one instruction; stall cycles with CE low must not be counted.
   task automatic exec(input logic [3:0] op, input logic [2:0] n_exp,
                       input logic [2:0] ld_exp, input int stall);
      int n;
      // The take edge is the instruction's first cycle.
      n = 1;
      rlog.delete();
      wlog.delete();
      START = 1'b1;
      OP_IN = op;
      @(posedge CLK);
      #1 START = 1'b0;
      if (stall > 0) begin
         CE = 1'b0;
         repeat (stall) @(posedge CLK);
         #1 CE = 1'b1;
      end
      while (n < 12) begin
         @(posedge CLK);
         #1 n++;
         if (DONE === 1'b1) break;
         `CHK(BUSY, 1'b1)
      end
      `CHK(n, int'(n_exp))
      `CHK({PC_LOAD, SP_LOAD, ACC_LOAD}, ld_exp)
   endtask : exec

   task automatic t_reset;
      `CHK({PC_OUT, SP_OUT, ACC_OUT, PTR_OUT}, 48'h0000_ff_00_0000)
      `CHK({BUSY, DONE, MEM_RD, MEM_WR}, 4'h0)
   endtask : t_reset

   task automatic t_next;
      mem[16'h1234] = 8'hcd;
      mem[16'h1235] = 8'hab;
      set_ptr(16'h1234);
      exec(OPC_NEXT, CYC_NEXT, 3'b100, 0);
      `CHK(PC_OUT, 16'habcd)
      `CHK(PTR_OUT, 16'h1236)
      `CHK(rlog[0], 16'h1234)
   endtask : t_next

   task automatic t_ldptr;
      mem[16'h2000] = 8'h34;
      mem[16'h2001] = 8'h12;
      set_ptr(16'h2000);
      exec(OPC_LDPTR, CYC_LDPTR, 3'b000, 0);
      `CHK(PTR_OUT, 16'h1234)
   endtask : t_ldptr

   task automatic t_ldacc_step;
      mem[16'h3000] = 8'h5a;
      set_ptr(16'h3000);
      exec(OPC_LDACC, CYC_LDACC, 3'b001, 0);
      `CHK(ACC_OUT, 8'h5a)
      `CHK(PTR_OUT, 16'h3000)
      set_ptr(16'hffff);
      exec(OPC_STEP, CYC_STEP, 3'b000, 3);
      `CHK(PTR_OUT, 16'h0000)
      `CHK(ACC_OUT, 8'h5a)
   endtask : t_ldacc_step

   task automatic t_stack;
      set_ptr(16'hbeef);
      SP_IN = 8'h80;
      exec(OPC_PUSH, CYC_PUSH, 3'b010, 0);
      `CHK(wlog[0], 16'h0180)
      `CHK({mem[16'h0180], mem[16'h017f]}, 16'hbeef)
      `CHK(SP_OUT, 8'h7e)
      set_ptr(16'h0000);
      SP_IN = 8'h7e;
      exec(OPC_PULL, CYC_PULL, 3'b010, 0);
      `CHK(rlog[0], 16'h017f)
      `CHK(PTR_OUT, 16'hbeef)
      `CHK(SP_OUT, 8'h80)
   endtask : t_stack

   // The return is taken in the call's DONE cycle, back to back.
   task automatic t_call_ret;
      mem[16'h4001] = 8'h00;
      mem[16'h4002] = 8'h50;
      PC_IN = 16'h4000;
      exec(OPC_CALL, CYC_CALL, 3'b100, 0);
      `CHK(rlog[0], 16'h4001)
      `CHK(PC_OUT, 16'h5000)
      `CHK(PTR_OUT, 16'h4003)
      exec(OPC_RET, CYC_RET, 3'b100, 0);
      `CHK(PC_OUT, 16'h4003)
   endtask : t_call_ret

   task automatic t_pullacc;
      mem[16'h017f] = 8'h00;
      mem[16'h0180] = 8'h60;
      mem[16'h6000] = 8'ha5;
      mem[16'h6001] = 8'h3c;
      SP_IN = 8'h7e;
      exec(OPC_PULLACC, CYC_PULLACC, 3'b011, 0);
      `CHK(PTR_OUT, 16'h6001)
      `CHK(SP_OUT, 8'h80)
      `CHK(ACC_OUT, 8'ha5)
      exec(OPC_LDSTEP, CYC_LDSTEP, 3'b001, 0);
      `CHK(ACC_OUT, 8'h3c)
      `CHK(PTR_OUT, 16'h6002)
   endtask : t_pullacc

   // An unknown code must be ignored without any sign of activity.
   task automatic t_illegal;
      START = 1'b1;
      OP_IN = 4'hf;
      @(posedge CLK);
      #1 START = 1'b0;
      repeat (6) begin
         @(posedge CLK);
         #1 `CHK({BUSY, DONE, PC_LOAD, MEM_RD}, 4'h0)
      end
      `CHK(PTR_OUT, 16'h6002)
   endtask : t_illegal

   initial begin
      repeat (6) @(posedge CLK);
      #1 ARST_N = 1'b1;
      t_reset();
      t_next();
      t_ldptr();
      t_ldacc_step();
      t_stack();
      t_call_ret();
      t_pullacc();
      t_illegal();
      print_verdict();
   end

   // The whole sequence needs about 70 cycles; this is ample margin.
   initial begin
      #(3000 * 100);
      err_total++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
